/* File: hw/led_sink_regs.vh */
// Constants for the eight-channel LED sink shift and latch logic
`ifndef LED_SINK_REGS_VH
`define LED_SINK_REGS_VH

// ****************************************
// Channel geometry
// ****************************************
`define LED_SINK_CHANNELS 8
`define LED_SINK_LAST 7
`define LED_SINK_RESET_BITS 8'h00

`endif

/* File: hw/led_sink_edge_detect.v */
// Edge detector for the sampled serial shift clock
`timescale 1ns/10ps

module led_sink_edge_detect (
    input wire clk_i,
    input wire sys_rst_i,
    input wire level_i,
    output reg rise_o,
    output reg fall_o
);

    reg level_r;

    // Hold previous level of the shift clock
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            level_r <= 1'b0;
        end else begin
            level_r <= level_i;
        end
    end

    // One-cycle pulses on each transition
    always @* begin
        rise_o = level_i & ~level_r;
        fall_o = ~level_i & level_r;
    end

endmodule

/* File: hw/led_sink_shift_latch.v */
// Serial-in, latched parallel-out control logic of an eight-channel LED sink driver
// Contract
// RULE1: Eight channels: stage, latch, enable gate.
// RULE2: Latches respond to strobe level, not edges.
// RULE3: Strobe low: latches hold their values.
// RULE4: Strobe high: latches pass shift register through.
// RULE5: Enable high forces all sinks off.
// RULE6: Enable low: each sink follows latch.
// RULE7: Cascade output updates on falling shift clock.
// RULE8: Rising edge shifts input toward stage seven.
`timescale 1ns/10ps
`include "led_sink_regs.vh"

module led_sink_shift_latch (
    input wire clk_i,
    input wire sys_rst_i,
    input wire serial_data_i,
    input wire shift_clk_i,
    input wire load_strobe_i,
    input wire output_enable_n_i,
    output reg [`LED_SINK_LAST:0] current_sinks_o,
    output reg cascade_data_o
);

    // ****************************************
    // Shift clock edge detection
    // ****************************************
    wire shift_rise;
    wire shift_fall;

    // Pulses on each transition of the sampled shift clock
    led_sink_edge_detect u_edge (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .level_i(shift_clk_i),
        .rise_o(shift_rise),
        .fall_o(shift_fall)
    );

    // ****************************************
    // Channel state
    // ****************************************
    reg [`LED_SINK_LAST:0] shift_r;
    reg [`LED_SINK_LAST:0] shift_nxt;
    reg [`LED_SINK_LAST:0] latch_r;
    reg [`LED_SINK_LAST:0] latch_nxt;
    reg [`LED_SINK_LAST:0] sinks_nxt;
    reg cascade_nxt;
    wire last_stage;

    // ****************************************
    // Helper functions
    // ****************************************
    // One shift step toward channel seven
    function [`LED_SINK_LAST:0] shift_step;
        input [`LED_SINK_LAST:0] cur;
        input din;
        begin
            shift_step[0] = din;
            shift_step[1] = cur[0];
            shift_step[2] = cur[1];
            shift_step[3] = cur[2];
            shift_step[4] = cur[3];
            shift_step[5] = cur[4];
            shift_step[6] = cur[5];
            shift_step[7] = cur[6];
        end
    endfunction

    // Level-sensitive cell: open passes, closed keeps
    function latch_cell;
        input open;
        input stored;
        input data;
        begin
            if (open) begin
                latch_cell = data;
            end else begin
                latch_cell = stored;
            end
        end
    endfunction

    // Disabled enable forces the sink off
    function gate_cell;
        input enable_n;
        input value;
        begin
            gate_cell = value & ~enable_n;
        end
    endfunction

    // ****************************************
    // Shift register
    // ****************************************
    // Shift only on a seen rising shift clock
    always @* begin
        shift_nxt = shift_r;
        if (shift_rise) begin
            shift_nxt = shift_step(shift_r, serial_data_i); // RULE8
        end
    end

    // Registered shift stages
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            shift_r <= `LED_SINK_RESET_BITS;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // ****************************************
    // Holding latches
    // ****************************************
    // Transparent while strobe high, hold while low
    always @* begin
        // Channel 0
        latch_nxt[0] = latch_cell(load_strobe_i, latch_r[0], shift_nxt[0]); // RULE2 RULE3 RULE4

        // Channel 1
        latch_nxt[1] = latch_cell(load_strobe_i, latch_r[1], shift_nxt[1]); // RULE2 RULE3 RULE4

        // Channel 2
        latch_nxt[2] = latch_cell(load_strobe_i, latch_r[2], shift_nxt[2]); // RULE2 RULE3 RULE4

        // Channel 3
        latch_nxt[3] = latch_cell(load_strobe_i, latch_r[3], shift_nxt[3]); // RULE2 RULE3 RULE4

        // Channel 4
        latch_nxt[4] = latch_cell(load_strobe_i, latch_r[4], shift_nxt[4]); // RULE2 RULE3 RULE4

        // Channel 5
        latch_nxt[5] = latch_cell(load_strobe_i, latch_r[5], shift_nxt[5]); // RULE2 RULE3 RULE4

        // Channel 6
        latch_nxt[6] = latch_cell(load_strobe_i, latch_r[6], shift_nxt[6]); // RULE2 RULE3 RULE4

        // Channel 7
        latch_nxt[7] = latch_cell(load_strobe_i, latch_r[7], shift_nxt[7]); // RULE2 RULE3 RULE4
    end

    // ****************************************
    // Registered latches
    // ****************************************
    // Latch contents kept across enable changes
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            latch_r <= `LED_SINK_RESET_BITS;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    // ****************************************
    // Output gating
    // ****************************************
    // Each sink follows its latch unless disabled
    always @* begin
        // Channel 0
        sinks_nxt[0] = gate_cell(output_enable_n_i, latch_nxt[0]); // RULE1 RULE5 RULE6

        // Channel 1
        sinks_nxt[1] = gate_cell(output_enable_n_i, latch_nxt[1]); // RULE1 RULE5 RULE6

        // Channel 2
        sinks_nxt[2] = gate_cell(output_enable_n_i, latch_nxt[2]); // RULE1 RULE5 RULE6

        // Channel 3
        sinks_nxt[3] = gate_cell(output_enable_n_i, latch_nxt[3]); // RULE1 RULE5 RULE6

        // Channel 4
        sinks_nxt[4] = gate_cell(output_enable_n_i, latch_nxt[4]); // RULE1 RULE5 RULE6

        // Channel 5
        sinks_nxt[5] = gate_cell(output_enable_n_i, latch_nxt[5]); // RULE1 RULE5 RULE6

        // Channel 6
        sinks_nxt[6] = gate_cell(output_enable_n_i, latch_nxt[6]); // RULE1 RULE5 RULE6

        // Channel 7
        sinks_nxt[7] = gate_cell(output_enable_n_i, latch_nxt[7]); // RULE1 RULE5 RULE6
    end

    // ****************************************
    // Registered sink outputs
    // ****************************************
    // Sinks come straight from flip-flops
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            current_sinks_o <= `LED_SINK_RESET_BITS;
        end else begin
            current_sinks_o <= sinks_nxt;
        end
    end

    // ****************************************
    // Cascade output
    // ****************************************
    // Bit leaving the last stage
    assign last_stage = shift_r[`LED_SINK_LAST];

    // Cascade moves only on a seen falling shift clock
    always @* begin
        cascade_nxt = cascade_data_o;
        if (shift_fall) begin
            cascade_nxt = last_stage; // RULE7
        end
    end

    // ****************************************
    // Registered cascade output
    // ****************************************
    // Cascade bit held between falling edges
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cascade_data_o <= 1'b0;
        end else begin
            cascade_data_o <= cascade_nxt;
        end
    end

endmodule

/* File: sim/led_sink_ctrl_model.sv */
// Controller model driving the serial side
`timescale 1ns/10ps
module led_sink_ctrl_model (input wire clk_i, output reg sclk_o = 1'b0, output reg sdat_o = 1'b0);
    // Byte out MSB first, clock held high two cycles and low three cycles per bit
    task send(input [7:0] b);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            @(posedge clk_i) sdat_o <= b[i];
            repeat (2) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        @(posedge clk_i) sdat_o <= ~sdat_o;
    endtask
endmodule

/* File: sim/led_sink_shift_latch_checker.sv */
// Checker for the LED sink shift and latch block
`timescale 1ns/10ps
module led_sink_checker (input wire clk_i, sys_rst_i, serial_data_i, shift_clk_i, load_strobe_i,
    output_enable_n_i, cascade_data_o, input wire [7:0] current_sinks_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sinks_forced_off_a: assert property (output_enable_n_i [*3] |-> current_sinks_o == 8'h00)
        else $error("sinks on while disabled");
    latch_hold_a: assert property ((!load_strobe_i && !output_enable_n_i) [*4] |=> $stable(current_sinks_o))
        else $error("latch changed while closed");
    cascade_quiet_a: assert property ($stable(shift_clk_i) [*3] |=> $stable(cascade_data_o))
        else $error("cascade moved without clock fall");
    sequence clk_rise_s;
        !shift_clk_i ##1 shift_clk_i;
    endsequence
    sequence open_enabled_s;
        load_strobe_i && !output_enable_n_i;
    endsequence
    sinks_off_next_a: assert property (output_enable_n_i |=> current_sinks_o == 8'h00)
        else $error("sinks on after disable");
    rise_shift_in_a: assert property (clk_rise_s ##0 open_enabled_s |=> current_sinks_o[0] == $past(serial_data_i))
        else $error("new bit not at channel zero");
    cascade_on_fall_a: assert property ($changed(cascade_data_o) |-> $past(shift_clk_i, 2) && !$past(shift_clk_i))
        else $error("cascade changed without fall");
endmodule
bind led_sink_shift_latch led_sink_checker chk (.*);

/* File: sim/led_sink_shift_latch_tb_top.sv */
// Bench for the LED sink shift and latch block
`timescale 1ns/10ps
module led_sink_shift_latch_tb_top;
    reg clk_i = 1'b0, sys_rst_i = 1'b1, load_strobe_i = 1'b0, output_enable_n_i = 1'b1;
    wire sclk, sdat, cascade_data_o;
    wire [7:0] current_sinks_o;
    integer n_errors = 0, n_tests = 0;
    initial forever #2.5 clk_i = ~clk_i;
    led_sink_ctrl_model P (.clk_i(clk_i), .sclk_o(sclk), .sdat_o(sdat));
    led_sink_shift_latch DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .serial_data_i(sdat), .shift_clk_i(sclk),
        .load_strobe_i(load_strobe_i), .output_enable_n_i(output_enable_n_i),
        .current_sinks_o(current_sinks_o), .cascade_data_o(cascade_data_o));
    task chk(input string n, input [7:0] e, g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    // Set strobe and enable, shift a byte, let outputs settle
    task run(input ls, oe, input [7:0] b);
        @(posedge clk_i) {load_strobe_i, output_enable_n_i} <= {ls, oe};
        P.send(b);
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task t_load; run(1, 0, 8'hA5);
        chk("sinks", 8'hA5, current_sinks_o);
        chk("cascade", 8'h01, {7'h00, cascade_data_o});
        $display("t_load done");
    endtask
    task t_hold; run(0, 0, 8'h3C);
        chk("sinks", 8'hA5, current_sinks_o);
        chk("cascade", 8'h00, {7'h00, cascade_data_o});
        $display("t_hold done");
    endtask
    task t_gate; run(0, 1, 8'h3C);
        chk("sinks", 8'h00, current_sinks_o);
        run(1, 0, 8'h3C);
        chk("sinks", 8'h3C, current_sinks_o);
        $display("t_gate done");
    endtask
    task finish_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #5000 n_errors = n_errors + 1;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_load;
        t_hold;
        t_gate;
        finish_test;
    end
endmodule
